// ==== bench/joystick_mode_control_assertions.sv ====
// joy_checker: port-level properties of the joystick mode block.
// assumes it is bound into joystick_mode_control on its single clock.
`timescale 1ns/10ps
module joy_checker (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire joy_pkg::mach_state_t mach_state,
    input wire logic probe_trigger,
    input wire logic external_damping_line,
    input wire logic probe_damped,
    input wire joy_pkg::axes_t demand_axes,
    input wire logic joystick_mode,
    input wire logic host_directed_mode,
    input wire logic machine_stop,
    input wire logic retreat_cmd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic rd;
    assign rd = psel && penable && !pwrite && paddr == joy_pkg::STATUS_OFS;

    a_mode_excl: assert property (joystick_mode != host_directed_mode)
        else $error("mode outputs agree");
    a_host_quiet: assert property (!$past(joystick_mode) |-> demand_axes == '0)
        else $error("lever demand outside joystick mode");
    a_enter_gate: assert property ($rose(joystick_mode) |->
        $past(mach_state) inside {joy_pkg::MACH_DISENGAGED, joy_pkg::MACH_HOLD})
        else $error("joystick mode entered while moving");
    a_leave_gate: assert property ($fell(joystick_mode) |->
        $past(mach_state) inside {joy_pkg::MACH_DISENGAGED, joy_pkg::MACH_HOLD})
        else $error("joystick mode left while moving");
    a_trigger_stop: assert property (
        probe_trigger && joystick_mode && mach_state == joy_pkg::MACH_JOG |-> ##[1:4] machine_stop)
        else $error("no stop after trigger");
    a_retreat_order: assert property ($rose(retreat_cmd) |-> $past(machine_stop))
        else $error("retreat without prior stop");
    a_null_hold: assert property ($fell(retreat_cmd) |-> (demand_axes == '0)[*8])
        else $error("demand not held after retreat");
    a_ext_damp: assert property (external_damping_line[*4] |=> probe_damped)
        else $error("external damping overridden");
    a_cancel_clear: assert property (rd ##3 rd |-> !prdata[joy_pkg::STAT_CANCEL_BIT])
        else $error("cancel flag survives a status read");
endmodule

bind joystick_mode_control joy_checker u_chk (.ref_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .mach_state, .probe_trigger, .external_damping_line, .probe_damped,
    .demand_axes, .joystick_mode, .host_directed_mode, .machine_stop, .retreat_cmd);

// ==== bench/joystick_mode_control_test.sv ====
// joystick_mode_control_test: table of orientation/damping cases, then directed tests.
// assumes motion_partner on the machine side; the bench is host and lever unit.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module joystick_mode_control_test;
    typedef struct packed {
        logic [1:0] pins;
        logic slow, ext, damp;
        logic [1:0] orient;
        logic [15:0] xabs;
        logic dmp;
    } row_t;
    row_t rows [4] = '{'{2'h3, 1'h1, 1'h0, 1'h1, 2'h0, 16'h5, 1'h0},
        '{2'h1, 1'h0, 1'h0, 1'h1, 2'h1, 16'h7, 1'h1},
        '{2'h0, 1'h1, 1'h1, 1'h0, 2'h2, 16'h5, 1'h1},
        '{2'h2, 1'h1, 1'h1, 1'h1, 2'h3, 16'h7, 1'h1}};
    logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] rdist;
    logic trig, rdone, ext, jmode, hmode, mstop, rcmd, damped;
    joy_pkg::switches_t sw;
    joy_pkg::locks_t locks, dlocks;
    joy_pkg::axes_t lever, pos, appr, demand, rvel;
    joy_pkg::mach_state_t state_req, mach_state;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    joystick_mode_control #(.NULL_WAIT_DEFAULT(20), .DEBOUNCE(2)) DUT (.ref_clk(ref_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .switches(sw),
        .lever_axes(lever), .lever_locks(locks), .mach_state(mach_state), .mach_pos(pos),
        .probe_trigger(trig), .approach_vel(appr), .retreat_done(rdone),
        .external_damping_line(ext), .demand_axes(demand), .demand_locks(dlocks),
        .joystick_mode(jmode), .host_directed_mode(hmode), .machine_stop(mstop),
        .retreat_cmd(rcmd), .retreat_vel(rvel), .retreat_dist(rdist), .probe_damped(damped));
    motion_partner u_mach (.ref_clk(ref_clk), .resetn(resetn), .state_req(state_req),
        .machine_stop(mstop), .retreat_cmd(rcmd), .mach_state(mach_state),
        .retreat_done(rdone));

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            test_done();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // bounded wait, then the level itself is the comparison
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++) @(posedge ref_clk);
        `CHK(s, v)
    endtask

    // debounce needs the pin held well past its stable count
    task automatic press(input logic cancel);
        @(posedge ref_clk);
        sw.record_point <= !cancel;
        sw.cancel_point <= cancel;
        repeat (10) @(posedge ref_clk);
        sw.record_point <= 1'h0;
        sw.cancel_point <= 1'h0;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic status(input int b, input logic e);
        apb(1'h0, joy_pkg::STATUS_OFS, 32'h0);
        `CHK(q[b], e)
    endtask

    initial begin
        {resetn, psel, penable, pwrite, trig, ext} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sw = 7'h03;
        locks = 3'h4;
        lever = {16'h5, 16'h7, 16'h9};
        pos = {16'h1234, 16'h0042, 16'h0007};
        appr = {16'h0064, 16'hFFCE, 16'h0};
        state_req = joy_pkg::MACH_DISENGAGED;
        repeat (6) @(posedge ref_clk);
        `CHK({hmode, jmode}, 2'h2)
        resetn <= 1'h1;
        sw.mode_switch <= 1'h1;
        sw.deadman <= 1'h1;
        apb(1'h1, joy_pkg::CTRL_OFS, 32'h6);
        repeat (10) @(posedge ref_clk);
        `CHK(jmode, 1'h0)
        $display("reset and mode request done");
        foreach (rows[i]) begin
            apb(1'h1, joy_pkg::CTRL_OFS, {28'h0, rows[i].damp, 3'h7});
            {sw.orient_first_n, sw.orient_second_n} <= rows[i].pins;
            sw.speed_slow <= rows[i].slow;
            ext <= rows[i].ext;
            repeat (12) @(posedge ref_clk);
            apb(1'h0, joy_pkg::STATUS_OFS, 32'h0);
            `CHK(q[13:12], rows[i].orient)
            `CHK(damped, rows[i].dmp)
            `CHK(demand.z, 16'h9)
            `CHK(demand.x[15] ? -demand.x : demand.x, rows[i].xabs)
            `CHK(dlocks, rows[i].orient[0] ? 3'h2 : 3'h4)
            $display("row %0d done", i);
        end
        ext <= 1'h0;
        state_req <= joy_pkg::MACH_JOG;
        {sw.orient_first_n, sw.orient_second_n} <= 2'h3;
        repeat (12) @(posedge ref_clk);
        status(12, 1'h1);
        state_req <= joy_pkg::MACH_HOLD;
        repeat (6) @(posedge ref_clk);
        apb(1'h0, joy_pkg::STATUS_OFS, 32'h0);
        `CHK(q[13:12], 2'h0)
        $display("orientation deferral done");
        apb(1'h1, joy_pkg::BACKOFF_OFS, 32'h0040_0123);
        state_req <= joy_pkg::MACH_JOG;
        lever <= {16'h3, 16'h0, 16'h0};
        repeat (3) @(posedge ref_clk);
        trig <= 1'h1;
        @(posedge ref_clk);
        trig <= 1'h0;
        wait_lvl(mstop, 1'h1);
        state_req <= joy_pkg::MACH_HOLD;
        wait_lvl(rcmd, 1'h1);
        `CHK(rdist, 16'h0040)
        `CHK({rvel.x[15], rvel.y[15]}, 2'h2)
        `CHK(rvel.y, 16'h0123)
        wait_lvl(rcmd, 1'h0);
        repeat (30) @(posedge ref_clk);
        `CHK(demand, 48'h0)
        lever <= 48'h0;
        repeat (30) @(posedge ref_clk);
        lever <= {16'h3, 16'h0, 16'h0};
        repeat (8) @(posedge ref_clk);
        `CHK(demand.x, 16'h3)
        $display("touch back-off done");
        press(1'h0);
        apb(1'h0, joy_pkg::POS_X_OFS, 32'h0);
        `CHK(q[15:0], 16'h1234)
        status(1, 1'h1);
        status(1, 1'h0);
        press(1'h1);
        status(2, 1'h1);
        status(2, 1'h0);
        press(1'h1);
        status(2, 1'h1);
        press(1'h0);
        press(1'h1);
        apb(1'h0, joy_pkg::STATUS_OFS, 32'h0);
        `CHK(q[2:1], 2'h0)
        $display("record and cancel done");
        apb(1'h1, joy_pkg::CTRL_OFS, 32'h6);
        repeat (10) @(posedge ref_clk);
        `CHK(jmode, 1'h1)
        lever <= 48'h0;
        repeat (10) @(posedge ref_clk);
        `CHK({hmode, jmode}, 2'h2)
        state_req <= joy_pkg::MACH_JOG;
        apb(1'h1, joy_pkg::CTRL_OFS, 32'h7);
        repeat (10) @(posedge ref_clk);
        `CHK(jmode, 1'h0)
        state_req <= joy_pkg::MACH_HOLD;
        repeat (5) @(posedge ref_clk);
        `CHK(jmode, 1'h1)
        {sw.orient_first_n, sw.orient_second_n} <= 2'h0;
        apb(1'h1, joy_pkg::CTRL_OFS, 32'h3);
        repeat (10) @(posedge ref_clk);
        status(13, 1'h0);
        apb(1'h0, 12'h024, 32'h0);
        `CHK({err, q}, 33'h1_0000_0000)
        $display("mode changes and bus refusal done");
        test_done();
    end
endmodule

// ==== bench/motion_partner.sv ====
// motion_partner: behavioural machine-side model for the joystick block.
// assumes the bench picks the machine state; stop and retreat are answered here.
`timescale 1ns/10ps
module motion_partner (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire joy_pkg::mach_state_t state_req,
    input wire logic machine_stop,
    input wire logic retreat_cmd,
    output joy_pkg::mach_state_t mach_state,
    output logic retreat_done
);
    logic [2:0] run_q;

    // a stop request wins over whatever state the bench asked for
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mach_state <= joy_pkg::MACH_DISENGAGED;
        end else begin
            mach_state <= machine_stop ? joy_pkg::MACH_HOLD : state_req;
        end
    end

    // retreat takes a few cycles, not an instant answer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 3'h0;
        end else begin
            run_q <= retreat_cmd ? ((run_q == 3'h4) ? run_q : run_q + 3'h1) : 3'h0;
        end
    end

    assign retreat_done = (run_q == 3'h4);
endmodule

// ==== inc/joy_pkg.sv ====
// joy_pkg: register map, field layouts, reset values, timing constants and
// carrier structs for the joystick mode and event block.
// assumes a 10 MHz controller clock and a 32-bit APB register bus.
package joy_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    // null wait figure held in microseconds (0.05 s)
    localparam int unsigned NULL_WAIT_US = 50_000;
    localparam int unsigned NULL_WAIT_CYC = (NULL_WAIT_US / 1000) * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC = 16;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] POS_X_OFS = 12'h008;
    localparam logic [11:0] POS_Y_OFS = 12'h00C;
    localparam logic [11:0] POS_Z_OFS = 12'h010;
    localparam logic [11:0] BACKOFF_OFS = 12'h014;
    localparam logic [11:0] NULLWAIT_OFS = 12'h018;
    localparam logic [11:0] ACK_OFS = 12'h01C;
    localparam logic [11:0] AXES_OFS = 12'h020;

    // control fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_TYPE_BIT = 1;
    localparam int unsigned CTRL_PRIMARY_BIT = 2;
    localparam int unsigned CTRL_DAMP_BIT = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // status word: byte seven occupies bits 7:0
    localparam int unsigned STAT_RECORD_BIT = 1;
    localparam int unsigned STAT_CANCEL_BIT = 2;
    localparam int unsigned STAT_MODE_BIT = 8;
    localparam int unsigned STAT_BACKOFF_BIT = 9;
    localparam int unsigned STAT_INHIBIT_BIT = 10;
    localparam int unsigned STAT_ORIENT_LSB = 12;

    localparam logic [31:0] BACKOFF_RST = 32'h0000_0000;
    localparam logic [31:0] NULLWAIT_RST = NULL_WAIT_CYC;

    typedef enum logic [1:0] {
        ORIENT_A,
        ORIENT_B,
        ORIENT_C,
        ORIENT_D
    } orient_t;

    // machine states reported by the motion controller
    typedef enum logic [1:0] {
        MACH_DISENGAGED,
        MACH_JOG,
        MACH_HOLD,
        MACH_OTHER
    } mach_state_t;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } axes_t;

    typedef struct packed {
        logic x;
        logic y;
        logic z;
    } locks_t;

    typedef struct packed {
        logic record_point;
        logic cancel_point;
        logic mode_switch;
        logic speed_slow;
        logic deadman;
        logic orient_first_n;
        logic orient_second_n;
    } switches_t;

endpackage

// ==== verilog/joystick_mode_control.sv ====
// joystick_mode_control: mode arbitration, touch back-off, null-wait re-arm,
// record/cancel point flags, damping override and orientation transpose.
// assumes an APB master on ref_clk, machine state and position from the
// motion controller on the same clock, and switch pins from the lever unit.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module joystick_mode_control #(
    parameter int unsigned NULL_WAIT_DEFAULT = joy_pkg::NULL_WAIT_CYC,
    parameter int unsigned DEBOUNCE = joy_pkg::DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lever unit pins
    input wire joy_pkg::switches_t switches,
    input wire joy_pkg::axes_t lever_axes,
    input wire joy_pkg::locks_t lever_locks,
    // motion controller side
    input wire joy_pkg::mach_state_t mach_state,
    input wire joy_pkg::axes_t mach_pos,
    input wire logic probe_trigger,
    input wire joy_pkg::axes_t approach_vel,
    input wire logic retreat_done,
    input wire logic external_damping_line,
    output joy_pkg::axes_t demand_axes,
    output joy_pkg::locks_t demand_locks,
    output logic joystick_mode,
    output logic host_directed_mode,
    output logic machine_stop,
    output logic retreat_cmd,
    output joy_pkg::axes_t retreat_vel,
    output logic [15:0] retreat_dist,
    output logic probe_damped
);
    joy_pkg::switches_t sw;
    logic [6:0] sw_clean;

    assign sw = joy_pkg::switches_t'(sw_clean);

    // orientation pins idle high when open, so they reset high
    switch_sync #(
        .WIDTH(7),
        .STABLE_CYC(DEBOUNCE),
        .RST_VAL(7'h03)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .raw(switches),
        .clean(sw_clean)
    );

    // lever deflection and locks come from pins too
    joy_pkg::axes_t axes_m_q, axes_s_q;
    joy_pkg::locks_t locks_m_q, locks_s_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            axes_m_q <= '0;
            axes_s_q <= '0;
            locks_m_q <= '0;
            locks_s_q <= '0;
        end else begin
            axes_m_q <= lever_axes;
            axes_s_q <= axes_m_q;
            locks_m_q <= lever_locks;
            locks_s_q <= locks_m_q;
        end
    end

    logic [31:0] ctrl_q, backoff_q, nullwait_q;
    logic wr_en, rd_en, status_rd, addr_ok;

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    always_comb begin
        unique case (paddr)
            joy_pkg::CTRL_OFS, joy_pkg::STATUS_OFS, joy_pkg::POS_X_OFS,
            joy_pkg::POS_Y_OFS, joy_pkg::POS_Z_OFS, joy_pkg::BACKOFF_OFS,
            joy_pkg::NULLWAIT_OFS, joy_pkg::ACK_OFS, joy_pkg::AXES_OFS:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    // a read of the status word is the position and status request
    assign status_rd = rd_en & (paddr == joy_pkg::STATUS_OFS);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= joy_pkg::CTRL_RST;
            backoff_q <= joy_pkg::BACKOFF_RST;
            nullwait_q <= 32'(NULL_WAIT_DEFAULT);
        end else if (wr_en) begin
            if (paddr == joy_pkg::CTRL_OFS) ctrl_q <= pwdata & 32'h0000_000F;
            if (paddr == joy_pkg::BACKOFF_OFS) backoff_q <= pwdata;
            if (paddr == joy_pkg::NULLWAIT_OFS) nullwait_q <= pwdata;
        end
    end

    logic safe_state, lever_active, mode_req, mode_q;

    assign safe_state = (mach_state == joy_pkg::MACH_DISENGAGED) ||
                        (mach_state == joy_pkg::MACH_HOLD);
    assign lever_active = (axes_s_q.x != 0) || (axes_s_q.y != 0) || (axes_s_q.z != 0)
                          || (mach_state == joy_pkg::MACH_JOG);
    assign mode_req = ctrl_q[joy_pkg::CTRL_ENABLE_BIT] & sw.mode_switch;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= 1'b0;
        end else if (mode_req && !mode_q && safe_state) begin
            mode_q <= 1'b1;
        end else if (!mode_req && mode_q && safe_state && !lever_active) begin
            mode_q <= 1'b0;
        end
    end
    assign joystick_mode = mode_q;
    assign host_directed_mode = ~mode_q;

    typedef enum logic [1:0] {
        TB_IDLE,
        TB_STOP,
        TB_RETREAT,
        TB_NULLWAIT
    } tb_state_t;
    tb_state_t tb_q;
    logic [31:0] null_cnt_q;
    logic all_null;
    joy_pkg::axes_t ret_vel_q;

    assign all_null = (axes_s_q.x == 0) && (axes_s_q.y == 0) && (axes_s_q.z == 0);

    function automatic logic signed [15:0] oppose(input logic signed [15:0] v,
                                                  input logic [15:0] spd);
        if (v > 0) return -$signed(spd);
        else if (v < 0) return $signed(spd);
        else return 16'sh0000;
    endfunction

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tb_q <= TB_IDLE;
            null_cnt_q <= '0;
            ret_vel_q <= '0;
        end else begin
            unique case (tb_q)
                TB_IDLE: begin
                    if (mode_q && probe_trigger && mach_state == joy_pkg::MACH_JOG) begin
                        tb_q <= TB_STOP;
                        ret_vel_q.x <= oppose(approach_vel.x, backoff_q[15:0]);
                        ret_vel_q.y <= oppose(approach_vel.y, backoff_q[15:0]);
                        ret_vel_q.z <= oppose(approach_vel.z, backoff_q[15:0]);
                    end
                end
                TB_STOP: begin
                    if (mach_state != joy_pkg::MACH_JOG) tb_q <= TB_RETREAT;
                end
                TB_RETREAT: begin
                    if (retreat_done) begin
                        tb_q <= TB_NULLWAIT;
                        null_cnt_q <= '0;
                    end
                end
                TB_NULLWAIT: begin
                    if (!all_null) begin
                        null_cnt_q <= '0;
                    end else if (null_cnt_q >= nullwait_q) begin
                        tb_q <= TB_IDLE;
                    end else begin
                        null_cnt_q <= null_cnt_q + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    assign machine_stop = (tb_q == TB_STOP);
    assign retreat_cmd = (tb_q == TB_RETREAT);
    assign retreat_vel = ret_vel_q;
    assign retreat_dist = backoff_q[31:16];

    joy_pkg::orient_t pin_orient, orient_q;
    logic orient_allowed;

    always_comb begin
        unique case ({sw.orient_first_n, sw.orient_second_n})
            2'b11: pin_orient = joy_pkg::ORIENT_A;
            2'b01: pin_orient = joy_pkg::ORIENT_B;
            2'b00: pin_orient = joy_pkg::ORIENT_C;
            2'b10: pin_orient = joy_pkg::ORIENT_D;
        endcase
    end

    assign orient_allowed = ctrl_q[joy_pkg::CTRL_TYPE_BIT] &
                            ctrl_q[joy_pkg::CTRL_PRIMARY_BIT];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            orient_q <= joy_pkg::ORIENT_A;
        end else if (!orient_allowed) begin
            orient_q <= joy_pkg::ORIENT_A;
        end else if (safe_state) begin
            orient_q <= pin_orient;
        end
    end

    // C is the opposite side of A: both X and Y reversed; B and D swap axes
    joy_pkg::axes_t xf_axes;
    joy_pkg::locks_t xf_locks;
    always_comb begin
        xf_axes.z = axes_s_q.z;
        xf_locks = locks_s_q;
        unique case (orient_q)
            joy_pkg::ORIENT_A: begin
                xf_axes.x = axes_s_q.x;
                xf_axes.y = axes_s_q.y;
            end
            joy_pkg::ORIENT_B: begin
                xf_axes.x = axes_s_q.y;
                xf_axes.y = -axes_s_q.x;
                xf_locks.x = locks_s_q.y;
                xf_locks.y = locks_s_q.x;
            end
            joy_pkg::ORIENT_C: begin
                xf_axes.x = -axes_s_q.x;
                xf_axes.y = -axes_s_q.y;
            end
            joy_pkg::ORIENT_D: begin
                xf_axes.x = -axes_s_q.y;
                xf_axes.y = axes_s_q.x;
                xf_locks.x = locks_s_q.y;
                xf_locks.y = locks_s_q.x;
            end
        endcase
    end

    // demand axes gated by mode and by the back-off sequence; demand locks pass through ungated
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            demand_axes <= '0;
            demand_locks <= '0;
        end else begin
            demand_locks <= xf_locks;
            if (mode_q && sw.deadman && tb_q == TB_IDLE) demand_axes <= xf_axes;
            else demand_axes <= '0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            probe_damped <= 1'b0;
        end else if (external_damping_line) begin
            probe_damped <= 1'b1;
        end else if (mode_q && sw.speed_slow) begin
            probe_damped <= 1'b0;
        end else begin
            probe_damped <= ctrl_q[joy_pkg::CTRL_DAMP_BIT];
        end
    end

    logic rec_d1_q, can_d1_q;
    logic rec_pulse, can_pulse;
    logic rec_flag_q, can_flag_q, read_q;
    joy_pkg::axes_t point_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rec_d1_q <= 1'b0;
            can_d1_q <= 1'b0;
        end else begin
            rec_d1_q <= sw.record_point;
            can_d1_q <= sw.cancel_point;
        end
    end
    assign rec_pulse = sw.record_point & ~rec_d1_q;
    assign can_pulse = sw.cancel_point & ~can_d1_q;

    // set wins over the clearing read in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rec_flag_q <= 1'b0;
            read_q <= 1'b0;
            point_q <= '0;
        end else if (rec_pulse) begin
            rec_flag_q <= 1'b1;
            read_q <= 1'b0;
            point_q <= mach_pos;
        end else if (can_pulse && rec_flag_q) begin
            rec_flag_q <= 1'b0;
            point_q <= '0;
        end else if (status_rd && rec_flag_q) begin
            rec_flag_q <= 1'b0;
            read_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            can_flag_q <= 1'b0;
        end else if (can_pulse && !rec_flag_q && read_q) begin
            can_flag_q <= 1'b1;
        end else if (status_rd) begin
            can_flag_q <= 1'b0;
        end
    end

    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[joy_pkg::STAT_RECORD_BIT] = rec_flag_q;
        status_word[joy_pkg::STAT_CANCEL_BIT] = can_flag_q;
        status_word[joy_pkg::STAT_MODE_BIT] = mode_q;
        status_word[joy_pkg::STAT_BACKOFF_BIT] = (tb_q != TB_IDLE);
        status_word[joy_pkg::STAT_INHIBIT_BIT] = (tb_q == TB_NULLWAIT);
        status_word[joy_pkg::STAT_ORIENT_LSB +: 2] = orient_q;
    end

    always_comb begin
        unique case (paddr)
            joy_pkg::CTRL_OFS: prdata = ctrl_q;
            joy_pkg::STATUS_OFS: prdata = status_word;
            joy_pkg::POS_X_OFS: prdata = {{16{point_q.x[15]}}, point_q.x};
            joy_pkg::POS_Y_OFS: prdata = {{16{point_q.y[15]}}, point_q.y};
            joy_pkg::POS_Z_OFS: prdata = {{16{point_q.z[15]}}, point_q.z};
            joy_pkg::BACKOFF_OFS: prdata = backoff_q;
            joy_pkg::NULLWAIT_OFS: prdata = nullwait_q;
            joy_pkg::AXES_OFS: prdata = {demand_axes.x, demand_axes.y};
            default: prdata = '0;
        endcase
    end
endmodule

// ==== verilog/switch_sync.sv ====
// switch_sync: two-flop synchroniser followed by a stable-count debouncer,
// one lane per input bit.
// assumes inputs are asynchronous pins sampled on ref_clk.
`timescale 1ns/10ps
module switch_sync #(
    parameter int unsigned WIDTH = 7,
    parameter int unsigned STABLE_CYC = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);
    localparam int unsigned CW = $clog2(STABLE_CYC + 1);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            logic meta_q;
            logic sync_q;
            logic [CW-1:0] cnt_q;
            logic out_q;

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_q <= RST_VAL[i];
                    sync_q <= RST_VAL[i];
                end else begin
                    meta_q <= raw[i];
                    sync_q <= meta_q;
                end
            end

            // output moves only after the new level has held for the full count
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_q <= '0;
                    out_q <= RST_VAL[i];
                end else if (sync_q == out_q) begin
                    cnt_q <= '0;
                end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
                    cnt_q <= '0;
                    out_q <= sync_q;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end

            assign clean[i] = out_q;
        end
    endgenerate
endmodule
